// file: inc/enwdg_pkg.sv
// Constants shared by the enable watchdog and reset event block.
`default_nettype none
package enwdg_pkg;
	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_EVENT = 4'h8;
	localparam logic [3:0] OFS_MASK = 4'hc;
	// Control register fields.
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_CLRF_BIT = 1;
	localparam logic CTRL_MODE_RST = 1'b0;
	// Status register fields.
	localparam int ST_LEVEL_BIT = 0;
	localparam int ST_VALID_BIT = 1;
	localparam int ST_SRDY_BIT = 2;
	localparam int ST_PRST_BIT = 3;
	localparam int ST_SHARD_BIT = 4;
	// Event register fields, shared with the mask register.
	localparam int EV_W = 7;
	localparam int EV_CLASS_A = 0;
	localparam int EV_CLASS_B = 1;
	localparam int EV_EXT_RST = 2;
	localparam int EV_PRI_RST = 3;
	localparam int EV_PRI_CER = 4;
	localparam int EV_SEC_CER = 5;
	localparam int EV_SEC_RST = 6;
	localparam logic [6:0] EV_RST = 7'h00;
	localparam logic [6:0] MASK_RST = 7'h00;
	// Synchronised pin inputs, index into one vector.
	localparam int IN_W = 12;
	localparam int IN_EN = 0;
	localparam int IN_RSTPIN = 1;
	localparam int IN_UV1 = 2;
	localparam int IN_PRIMARY_OSCILLATOR = 3;
	localparam int IN_REF1 = 4;
	localparam int IN_MEM1 = 5;
	localparam int IN_UV2 = 6;
	localparam int IN_OSC2S = 7;
	localparam int IN_MEM2 = 8;
	localparam int IN_OSC2M = 9;
	localparam int IN_LIFE = 10;
	localparam int IN_OSD = 11;
	// Watchdog timing in counter states; the counter runs at clk / 8.
	localparam int WD_DIV = 8;
	localparam logic [2:0] WD_PRE_LAST = 3'(WD_DIV - 1);
	localparam logic [2:0] WD_WIN_LO = 3'h2;
	localparam logic [2:0] WD_WIN_HI = 3'h6;
	localparam logic [1:0] WD_GOOD_NEED = 2'h2;
	// Operating mode codes from the mode state machine.
	localparam logic [2:0] OPM_INITIAL = 3'h0;
	localparam logic [2:0] OPM_FAULT_LOW = 3'h3;
	localparam logic [2:0] OPM_FAULT_HIGH = 3'h5;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : enwdg_pkg
`default_nettype wire

// file: inc/enwdg_wd_if.sv
// Signals between the supervisor top and its enable watchdog.
`default_nettype none
interface enwdg_wd_if;
	logic en_level;
	logic mode_clk;
	logic valid;
	logic violation;
	modport wd(input en_level, input mode_clk, output valid, output violation);
	modport ctl(output en_level, output mode_clk, input valid, input violation);
endinterface : enwdg_wd_if
`default_nettype wire

// file: src/enwdg_watchdog.sv
// Window watchdog that checks the clocked enable input half-period by half-period.
`default_nettype none
module enwdg_watchdog (
	input wire logic clk, // System clock, taken as the primary oscillator.
	input wire logic nrst, // Asynchronous reset, active low.
	enwdg_wd_if.wd wd // Enable level in, validity and violation out.
);
	logic [2:0] pre_q;
	logic [2:0] cnt_q;
	logic [1:0] good_q;
	logic en_prev_q;
	logic armed_q;
	logic valid_q;
	logic viol_q;
	logic edge_seen;
	logic tick;
	logic in_win;
	logic late_hit;
	logic bad;

	// Edge, prescaler tick and window decode.
	assign edge_seen = wd.en_level ^ en_prev_q;
	assign tick = pre_q == enwdg_pkg::WD_PRE_LAST;
	assign in_win = cnt_q >= enwdg_pkg::WD_WIN_LO && cnt_q <= enwdg_pkg::WD_WIN_HI;
	assign late_hit = armed_q && !edge_seen && tick && cnt_q == enwdg_pkg::WD_WIN_HI;
	assign bad = armed_q && ((edge_seen && !in_win) || late_hit);

	// Prescaler and half-period counter restart on every edge.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pre_q <= 3'h0;
			cnt_q <= 3'h0;
			en_prev_q <= 1'b0;
		end else begin
			en_prev_q <= wd.en_level;
			if (!wd.mode_clk || edge_seen) begin
				pre_q <= 3'h0;
				cnt_q <= 3'h0;
			end else begin
				pre_q <= pre_q + 3'h1;
				// The counter saturates past the window so a dead input flags only once.
				if (tick && armed_q && cnt_q <= enwdg_pkg::WD_WIN_HI) begin
					cnt_q <= cnt_q + 3'h1;
				end
			end
		end
	end

	// The first edge after entering clocked mode only starts timing; it has no reference.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			armed_q <= 1'b0;
			good_q <= 2'h0;
			valid_q <= 1'b0;
			viol_q <= 1'b0;
		end else if (!wd.mode_clk) begin
			armed_q <= 1'b0;
			good_q <= 2'h0;
			valid_q <= 1'b0;
			viol_q <= 1'b0;
		end else begin
			viol_q <= bad;
			if (edge_seen) begin
				armed_q <= 1'b1;
			end
			if (bad) begin
				good_q <= 2'h0;
				valid_q <= 1'b0;
			end else if (edge_seen && armed_q && good_q != enwdg_pkg::WD_GOOD_NEED) begin
				good_q <= good_q + 2'h1;
				valid_q <= good_q + 2'h1 == enwdg_pkg::WD_GOOD_NEED;
			end
		end
	end

	assign wd.valid = valid_q;
	assign wd.violation = viol_q;
endmodule : enwdg_watchdog
`default_nettype wire

// file: src/enwdg_top.sv
// Enable supervision and reset event handling with an AXI4-Lite register slave.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`default_nettype none
module enwdg_top (
	input wire logic clk, // System clock, 40 MHz.
	input wire logic nrst, // Asynchronous reset, active low.
	input wire logic [3:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [3:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	output logic irq, // Interrupt, high while an unmasked event is set.
	input wire logic enable_input, // Enable pin, level or clock.
	input wire logic reset_ready_in, // Reset/ready pin level, low is reset.
	output logic reset_ready_out, // Reset/ready pin drive value.
	output logic reset_ready_oe_n, // Reset/ready pin enable, low drives.
	input wire logic primary_undervoltage, // Primary supply low.
	input wire logic primary_osc_fail, // Primary oscillator did not start.
	input wire logic primary_ref_fault, // Primary reference shorted or open.
	input wire logic primary_mem_error, // Primary memory error.
	input wire logic secondary_undervoltage, // Secondary supply low.
	input wire logic secondary_osc_fail, // Secondary oscillator did not start.
	input wire logic secondary_mem_error, // Secondary memory error.
	input wire logic secondary_osc_bad, // Secondary oscillator malfunction.
	input wire logic lifesign_lost, // Lifesign between chips lost.
	input wire logic output_disable_input, // Output disable pin, high tristates.
	input wire logic [2:0] op_mode, // Current operating mode code.
	input wire logic pwm_on, // Turn-on command of the driver logic.
	input wire logic clamp_inhibit_req, // Clamp inhibit wanted by the driver logic.
	input wire logic sdo_data, // Serial data from the interface logic.
	input wire logic monitor_data, // Digital monitor data.
	output logic force_initial_mode, // Forces the initial mode, level.
	output logic enable_ok, // Enable input currently valid.
	output logic fault_a_out, // Fault notification A, active low.
	output logic fault_b_out, // Fault notification B, active low.
	output logic sdo_out, // Serial data output.
	output logic monitor_out, // Digital monitor drive value.
	output logic monitor_oe_n, // Digital monitor enable, low drives.
	output logic turn_on_output, // Turn-on stage command.
	output logic turn_off_output, // Turn-off stage command.
	output logic gate_output, // Gate stage command.
	output logic output_tristate, // Output stage tristated.
	output logic desaturation_input_clamp, // Desaturation input clamp.
	output logic clamp_inhibit_out, // Clamp inhibit, high disables clamping.
	output logic secondary_undervoltage_n // Secondary undervoltage output, low active.
);
	enwdg_wd_if wd_bus ();
	logic [enwdg_pkg::IN_W-1:0] sync1_q;
	logic [enwdg_pkg::IN_W-1:0] sync2_q;
	logic mode_q;
	logic [6:0] ev_q;
	logic [6:0] ev_set;
	logic [6:0] ev_clr;
	logic [6:0] mask_q;
	logic valid_q;
	logic valid_now;
	logic fault_a_q;
	logic fault_b_q;
	logic fault_clr;
	logic pri_drive;
	logic ext_rst;
	logic pri_rst;
	logic pri_rst_q;
	logic pri_int_q;
	logic [2:0] drv_hist_q;
	logic sec_hard;
	logic sec_fault;
	logic sec_fault_q;
	logic uv2_q;
	logic srdy_q;
	logic stage_off;
	logic aw_v_q;
	logic [3:0] aw_a_q;
	logic w_v_q;
	logic [31:0] w_d_q;
	logic [3:0] w_s_q;
	logic do_write;
	logic wr_ok;
	logic [31:0] rd_word;
	logic rd_ok;

	// Every pin input passes two flops before any logic looks at it.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {output_disable_input, lifesign_lost, secondary_osc_bad,
				secondary_mem_error, secondary_osc_fail, secondary_undervoltage,
				primary_mem_error, primary_ref_fault, primary_osc_fail,
				primary_undervoltage, reset_ready_in, enable_input};
			sync2_q <= sync1_q;
		end
	end

	// Reset source decode; the pin only counts as external while we are not pulling it.
	assign pri_drive = sync2_q[enwdg_pkg::IN_UV1] | sync2_q[enwdg_pkg::IN_PRIMARY_OSCILLATOR]
		| sync2_q[enwdg_pkg::IN_REF1] | sync2_q[enwdg_pkg::IN_MEM1];
	// Our own pull needs three cycles to leave the synchroniser, so it must not read back as an external reset.
	// An external reset that starts within those three cycles is seen late.
	assign ext_rst = !sync2_q[enwdg_pkg::IN_RSTPIN] && !pri_drive && drv_hist_q == 3'h0;
	assign pri_rst = ext_rst || pri_drive;
	assign sec_hard = sync2_q[enwdg_pkg::IN_UV2] | sync2_q[enwdg_pkg::IN_OSC2S]
		| sync2_q[enwdg_pkg::IN_MEM2];
	assign sec_fault = sec_hard | sync2_q[enwdg_pkg::IN_OSC2M];

	// Edge history of the reset sources, used for start- and end-of-event notifications and the pin read-back mask.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pri_rst_q <= 1'b0;
			pri_int_q <= 1'b0;
			drv_hist_q <= 3'h0;
			sec_fault_q <= 1'b0;
			uv2_q <= 1'b0;
		end else begin
			pri_rst_q <= pri_rst;
			pri_int_q <= pri_drive;
			drv_hist_q <= {drv_hist_q[1:0], pri_drive};
			sec_fault_q <= sec_fault;
			uv2_q <= sync2_q[enwdg_pkg::IN_UV2];
		end
	end

	// Ready flag of the secondary follows the failure directly.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			srdy_q <= 1'b0;
		end else begin
			srdy_q <= !sec_fault;
		end
	end

	// Enable validity per mode, with the watchdog doing the clocked case.
	assign wd_bus.en_level = sync2_q[enwdg_pkg::IN_EN];
	assign wd_bus.mode_clk = mode_q;
	assign valid_now = mode_q ? wd_bus.valid : sync2_q[enwdg_pkg::IN_EN];

	enwdg_watchdog u_watchdog (
		.clk(clk),
		.nrst(nrst),
		.wd(wd_bus)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			valid_q <= 1'b0;
		end else begin
			valid_q <= valid_now;
		end
	end

	// Event sources; a set arriving with a software clear still lands.
	always_comb begin
		ev_set = '0;
		ev_set[enwdg_pkg::EV_CLASS_A] = (valid_q && !valid_now)
			|| (mode_q && wd_bus.violation);
		ev_set[enwdg_pkg::EV_CLASS_B] = (pri_rst_q && !pri_rst)
			|| (sec_fault && !sec_fault_q);
		ev_set[enwdg_pkg::EV_EXT_RST] = ext_rst;
		ev_set[enwdg_pkg::EV_PRI_RST] = ext_rst || (pri_int_q && !pri_drive);
		ev_set[enwdg_pkg::EV_PRI_CER] = sec_fault && !sec_fault_q;
		ev_set[enwdg_pkg::EV_SEC_CER] = pri_rst && sync2_q[enwdg_pkg::IN_LIFE];
		ev_set[enwdg_pkg::EV_SEC_RST] = uv2_q && !sync2_q[enwdg_pkg::IN_UV2];
	end

	// Write-one-to-clear of the event register.
	assign ev_clr = (do_write && aw_a_q == enwdg_pkg::OFS_EVENT && w_s_q[0]) ? w_d_q[6:0] : 7'h00;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ev_q <= enwdg_pkg::EV_RST;
		end else begin
			ev_q <= (ev_q & ~ev_clr) | ev_set;
		end
	end

	assign irq = |(ev_q & mask_q);

	// Configuration returns to defaults on any primary reset while the clock keeps running.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= enwdg_pkg::CTRL_MODE_RST;
			mask_q <= enwdg_pkg::MASK_RST;
		end else if (pri_rst) begin
			mode_q <= enwdg_pkg::CTRL_MODE_RST;
			mask_q <= enwdg_pkg::MASK_RST;
		end else if (do_write && w_s_q[0]) begin
			if (aw_a_q == enwdg_pkg::OFS_CTRL) begin
				mode_q <= w_d_q[enwdg_pkg::CTRL_MODE_BIT];
			end
			if (aw_a_q == enwdg_pkg::OFS_MASK) begin
				mask_q <= w_d_q[6:0];
			end
		end
	end

	// Fault latches: a notification set in the same cycle as a clear stays set.
	assign fault_clr = (do_write && w_s_q[0] && aw_a_q == enwdg_pkg::OFS_CTRL
		&& w_d_q[enwdg_pkg::CTRL_CLRF_BIT])
		|| (!valid_q && valid_now && (op_mode == enwdg_pkg::OPM_FAULT_LOW
		|| op_mode == enwdg_pkg::OPM_FAULT_HIGH));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fault_a_q <= 1'b0;
			fault_b_q <= 1'b0;
		end else begin
			fault_a_q <= ev_set[enwdg_pkg::EV_CLASS_A] || (fault_a_q && !fault_clr);
			fault_b_q <= ev_set[enwdg_pkg::EV_CLASS_B] || (fault_b_q && !fault_clr);
		end
	end

	// Primary pin levels; reset overrides normal notification drive.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fault_a_out <= 1'b1;
			fault_b_out <= 1'b0;
			sdo_out <= 1'b0;
			monitor_out <= 1'b0;
			monitor_oe_n <= 1'b1;
			reset_ready_out <= 1'b0;
			reset_ready_oe_n <= 1'b0;
			force_initial_mode <= 1'b1;
			enable_ok <= 1'b0;
		end else begin
			fault_a_out <= pri_rst || !fault_a_q;
			fault_b_out <= !pri_rst && !fault_b_q;
			sdo_out <= !pri_rst && sdo_data;
			monitor_out <= monitor_data;
			monitor_oe_n <= pri_rst;
			reset_ready_out <= 1'b0;
			reset_ready_oe_n <= !pri_drive;
			force_initial_mode <= pri_rst || sec_fault;
			enable_ok <= valid_now;
		end
	end

	// Secondary stage: any reset turns the stage off, the disable pin always works.
	assign stage_off = pri_rst || sec_fault || !valid_now;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			turn_on_output <= 1'b0;
			turn_off_output <= 1'b0;
			gate_output <= 1'b0;
			output_tristate <= 1'b0;
			desaturation_input_clamp <= 1'b1;
			clamp_inhibit_out <= 1'b1;
			secondary_undervoltage_n <= 1'b0;
		end else begin
			turn_on_output <= !stage_off && pwm_on;
			// Holding turn-off high is the off command; only a hard reset clamps it low.
			turn_off_output <= !sec_hard && !(pwm_on && !stage_off);
			gate_output <= !stage_off && pwm_on;
			output_tristate <= sync2_q[enwdg_pkg::IN_OSD];
			desaturation_input_clamp <= sec_hard;
			clamp_inhibit_out <= sec_hard || clamp_inhibit_req;
			secondary_undervoltage_n <= !sec_hard;
		end
	end

	// AXI4-Lite write: address and data are caught independently, then committed together.
	assign s_axi_awready = !aw_v_q;
	assign s_axi_wready = !w_v_q;
	assign do_write = aw_v_q && w_v_q && !s_axi_bvalid;
	assign wr_ok = aw_a_q == enwdg_pkg::OFS_CTRL || aw_a_q == enwdg_pkg::OFS_STATUS
		|| aw_a_q == enwdg_pkg::OFS_EVENT || aw_a_q == enwdg_pkg::OFS_MASK;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_v_q <= 1'b0;
			aw_a_q <= 4'h0;
			w_v_q <= 1'b0;
			w_d_q <= 32'h0;
			w_s_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= enwdg_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_v_q) begin
				aw_v_q <= 1'b1;
				aw_a_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_v_q <= 1'b0;
			end
			if (s_axi_wvalid && !w_v_q) begin
				w_v_q <= 1'b1;
				w_d_q <= s_axi_wdata;
				w_s_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_v_q <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? enwdg_pkg::RESP_OKAY : enwdg_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read decode; the status word shows live block state.
	always_comb begin
		rd_word = 32'h0;
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			enwdg_pkg::OFS_CTRL: rd_word[enwdg_pkg::CTRL_MODE_BIT] = mode_q;
			enwdg_pkg::OFS_STATUS: begin
				rd_word[enwdg_pkg::ST_LEVEL_BIT] = sync2_q[enwdg_pkg::IN_EN];
				rd_word[enwdg_pkg::ST_VALID_BIT] = valid_now;
				rd_word[enwdg_pkg::ST_SRDY_BIT] = srdy_q;
				rd_word[enwdg_pkg::ST_PRST_BIT] = pri_rst;
				rd_word[enwdg_pkg::ST_SHARD_BIT] = sec_hard;
			end
			enwdg_pkg::OFS_EVENT: rd_word[6:0] = ev_q;
			enwdg_pkg::OFS_MASK: rd_word[6:0] = mask_q;
			default: rd_ok = 1'b0;
		endcase
	end

	// AXI4-Lite read: one outstanding read, data registered at the address handshake.
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= enwdg_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? enwdg_pkg::RESP_OKAY : enwdg_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : enwdg_top
`default_nettype wire

// file: bench/enwdg_sva.sv
// Port checker for the enable supervision and reset event block.
`default_nettype none
module enwdg_sva (
	input wire logic clk, // Clock.
	input wire logic nrst, // Reset, low active.
	input wire logic enable_input, // Enable pin.
	input wire logic enable_ok, // Enable valid.
	input wire logic primary_undervoltage, // Supply low.
	input wire logic primary_osc_fail, // Start fault.
	input wire logic primary_ref_fault, // Reference fault.
	input wire logic primary_mem_error, // Memory fault.
	input wire logic secondary_undervoltage, // Supply low.
	input wire logic secondary_mem_error, // Memory fault.
	input wire logic secondary_osc_bad, // Clock fault.
	input wire logic output_disable_input, // Disable pin.
	input wire logic sdo_out, // Serial data.
	input wire logic monitor_oe_n, // Monitor enable.
	input wire logic fault_a_out, // Fault A.
	input wire logic fault_b_out, // Fault B.
	input wire logic reset_ready_oe_n, // Pin enable.
	input wire logic force_initial_mode, // Initial mode.
	input wire logic turn_on_output, // Turn-on.
	input wire logic turn_off_output, // Turn-off.
	input wire logic gate_output, // Gate.
	input wire logic output_tristate, // Tristate.
	input wire logic desaturation_input_clamp, // Desaturation_input clamp.
	input wire logic clamp_inhibit_out, // Clamp inhibit.
	input wire logic secondary_undervoltage_n // Undervoltage out.
);
	timeunit 1ns;
	timeprecision 100ps;
	logic lv_q;
	logic [6:0] st_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// Counts how long the pin has held its level; it saturates so a long idle stays long.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lv_q <= 1'h0;
			st_q <= 7'h00;
		end else begin
			lv_q <= enable_input;
			st_q <= (enable_input != lv_q) ? 7'h00 : st_q + {6'h00, st_q != 7'h7f};
		end
	end
	// Four samples cover the two synchroniser stages and the output register.
	a_pri_rst_pins: assert property (primary_undervoltage [*4] |->
		!sdo_out && monitor_oe_n && !fault_b_out && fault_a_out && !reset_ready_oe_n) else $error("primary reset pins");
	a_sec_hard_pins: assert property (secondary_undervoltage [*4] |->
		!turn_on_output && !turn_off_output && !gate_output && desaturation_input_clamp && clamp_inhibit_out
		&& !secondary_undervoltage_n) else $error("secondary hard reset pins");
	a_sec_out_off: assert property (secondary_mem_error [*4] |->
		!turn_on_output && !gate_output && force_initial_mode) else $error("output not off");
	a_osd_kept: assert property ((primary_ref_fault && output_disable_input) [*4] |->
		output_tristate && !turn_on_output) else $error("output disable lost");
	a_soft_init: assert property (secondary_osc_bad [*4] |->
		force_initial_mode && !turn_on_output) else $error("soft reset not in initial mode");
	a_classb_start: assert property ($rose(secondary_undervoltage) |->
		##[1:6] !fault_b_out) else $error("fault B not raised");
	a_pin_release: assert property ($fell(primary_undervoltage) && !primary_osc_fail && !primary_ref_fault
		&& !primary_mem_error |-> ##[2:8] reset_ready_oe_n) else $error("reset pin still driven");
	a_enable_low: assert property (st_q > 7'h50 && !lv_q |-> !enable_ok)
		else $error("enable valid while pin low");
	c_enable_valid: cover property ($rose(enable_ok));
	c_pin_driven: cover property ($fell(reset_ready_oe_n));
	c_sec_hard: cover property ($fell(secondary_undervoltage_n));
endmodule : enwdg_sva
bind enwdg_top enwdg_sva i_sva (.*);
`default_nettype wire

// file: bench/enwdg_mcu_model.sv
// Controller model that drives the enable pin as a level or as a clock.
`default_nettype none
module enwdg_mcu_model (
	input wire logic clk, // Clock.
	input wire logic run, // High toggles the pin.
	input wire logic lvl, // Level held while idle.
	input wire logic [7:0] half, // Half-period in cycles.
	output logic enable_input // Enable pin.
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] cnt;
	// The pin is always driven actively, never left floating.
	initial begin
		enable_input = 1'h0;
		cnt = 8'h01;
	end
	// A changed half-period applies at once to the half-period in progress, so a scenario can push timing out of the window.
	always @(posedge clk) begin
		if (!run) begin
			enable_input <= lvl;
			cnt <= 8'h01;
		end else if (cnt >= half) begin
			enable_input <= ~enable_input;
			cnt <= 8'h01;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule : enwdg_mcu_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the enable supervision and reset event block.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] pf = 4'h0, sf = 4'h0;
	logic [2:0] op_mode = 3'h0;
	logic [7:0] half = 8'h20;
	logic primary_undervoltage, primary_osc_fail, primary_ref_fault, primary_mem_error;
	logic secondary_undervoltage, secondary_osc_fail, secondary_mem_error, secondary_osc_bad;
	logic lifesign_lost = 1'h0, output_disable_input = 1'h0, ext_low = 1'h0, run = 1'h0, lvl = 1'h0;
	logic pwm_on = 1'h1, clamp_inhibit_req = 1'h0, sdo_data = 1'h1, monitor_data = 1'h1;
	logic enable_input, reset_ready_in, reset_ready_out, reset_ready_oe_n, force_initial_mode, enable_ok;
	logic fault_a_out, fault_b_out, sdo_out, monitor_out, monitor_oe_n, turn_on_output, turn_off_output;
	logic gate_output, output_tristate, desaturation_input_clamp, clamp_inhibit_out, secondary_undervoltage_n;
	int num_errors = 0;
	int tests_run = 0;
	logic [7:0] hp [4] = '{8'h14, 8'h2c, 8'h0a, 8'h46};
	// Fault inputs travel as vectors so one loop can walk through them.
	assign {primary_mem_error, primary_ref_fault, primary_osc_fail, primary_undervoltage} = pf;
	assign {secondary_osc_bad, secondary_mem_error, secondary_osc_fail, secondary_undervoltage} = sf;
	// Open-drain reset pin with a pull-up: low if either side pulls it.
	assign reset_ready_in = (reset_ready_oe_n | reset_ready_out) & ~ext_low;
	enwdg_top i_dut (.*);
	enwdg_mcu_model i_mcu (.*);
	// Clock at 40 MHz.
	always #12.5 clk = ~clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// Handshakes are sampled at the falling edge, so the rising edge that takes them is never raced.
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ha, hw, hb;
		logic [1:0] r;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		hb = 1'h0;
		while (!hb) begin
			@(negedge clk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (ha) s_axi_awvalid <= 1'h0;
			if (hw) s_axi_wvalid <= 1'h0;
		end
		s_axi_bready <= 1'h0;
		chk(r, er);
	endtask : wr
	task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		logic ha, hb;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		hb = 1'h0;
		while (!hb) begin
			@(negedge clk);
			ha = s_axi_arvalid && s_axi_arready;
			hb = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ha) s_axi_arvalid <= 1'h0;
		end
		s_axi_rready <= 1'h0;
		chk(d & m, e);
		chk(r, er);
	endtask : rdc
	task automatic t_after_reset;
		rdc(4'h8, 32'h7e, 32'h0e, 2'h0);
		chk(fault_b_out, 1'h0);
		chk(irq, 1'h0);
		wr(4'h8, 32'h7f, 2'h0);
		rdc(4'h2, 32'hffffffff, 32'h0, 2'h2);
		wr(4'h2, 32'h1, 2'h2);
	endtask : t_after_reset
	task automatic t_level;
		lvl <= 1'h1;
		cyc(8);
		rdc(4'h4, 32'h1f, 32'h07, 2'h0);
		chk(enable_ok, 1'h1);
		wr(4'hc, 32'h01, 2'h0);
		lvl <= 1'h0;
		cyc(8);
		rdc(4'h4, 32'h1f, 32'h04, 2'h0);
		chk({irq, fault_a_out}, 2'h2);
		wr(4'h8, 32'h01, 2'h0);
		chk(irq, 1'h0);
	endtask : t_level
	// Mode 0 must keep the notifications; the fault-latched modes release them.
	task automatic t_notify;
		for (int i = 0; i < 3; i++) begin
			lvl <= 1'h0;
			cyc(8);
			op_mode <= (i == 0) ? 3'h0 : ((i == 1) ? 3'h3 : 3'h5);
			lvl <= 1'h1;
			cyc(8);
			chk({fault_a_out, fault_b_out}, {2{i != 0}});
		end
		// A software clear through the control word releases the latched notification.
		lvl <= 1'h0;
		cyc(8);
		chk({fault_a_out, fault_b_out, monitor_out}, 3'h3);
		wr(4'h0, 32'h2, 2'h0);
		cyc(2);
		chk({fault_a_out, fault_b_out}, 2'h3);
	endtask : t_notify
	// Half-periods near both window edges pass; too short or too long fail.
	task automatic t_clocked;
		wr(4'h0, 32'h1, 2'h0);
		run <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			half <= hp[i];
			cyc(150);
			chk(enable_ok, i < 2);
			wr(4'h8, 32'h7f, 2'h0);
			cyc(200);
			rdc(4'h8, 32'h1, {31'h0, i > 1}, 2'h0);
			rdc(4'h4, 32'h2, {30'h0, i < 2, 1'h0}, 2'h0);
		end
	endtask : t_clocked
	task automatic t_pri_rst;
		run <= 1'h0;
		lvl <= 1'h0;
		for (int j = 0; j < 5; j++) begin
			wr(4'h0, 32'h1, 2'h0);
			wr(4'hc, 32'h7f, 2'h0);
			wr(4'h8, 32'h7f, 2'h0);
			pf <= 4'h1 << j;
			ext_low <= (j == 4);
			lifesign_lost <= 1'h1;
			output_disable_input <= 1'h1;
			cyc(10);
			chk({sdo_out, monitor_oe_n, fault_b_out, fault_a_out, reset_ready_in}, 5'h0a);
			chk({force_initial_mode, output_tristate, turn_on_output}, 3'h6);
			pf <= 4'h0;
			ext_low <= 1'h0;
			lifesign_lost <= 1'h0;
			output_disable_input <= 1'h0;
			cyc(10);
			rdc(4'h8, 32'h7e, (j == 4) ? 32'h2e : 32'h2a, 2'h0);
			rdc(4'h0, 32'h1, 32'h0, 2'h0);
			rdc(4'hc, 32'h7f, 32'h0, 2'h0);
		end
	endtask : t_pri_rst
	task automatic t_sec;
		for (int k = 0; k < 4; k++) begin
			wr(4'h8, 32'h7f, 2'h0);
			sf <= 4'h1 << k;
			cyc(10);
			rdc(4'h4, 32'h14, (k < 3) ? 32'h10 : 32'h0, 2'h0);
			chk({force_initial_mode, turn_on_output, gate_output}, 3'h4);
			if (k < 3) chk({turn_off_output, desaturation_input_clamp, clamp_inhibit_out, secondary_undervoltage_n}, 4'h6);
			sf <= 4'h0;
			cyc(10);
			rdc(4'h8, 32'h7e, (k == 0) ? 32'h52 : 32'h12, 2'h0);
		end
	endtask : t_sec
	task automatic final_report;
		$display("errors %0d in %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	// Main sequence: hold reset for three cycles, then run the scenarios.
	initial begin
		cyc(3);
		nrst <= 1'h1;
		cyc(6);
		t_after_reset;
		t_level;
		t_notify;
		t_clocked;
		t_pri_rst;
		t_sec;
		final_report;
	end
	// The scenarios need about 1900 cycles; this limit leaves ample margin.
	initial begin
		#300us;
		num_errors++;
		final_report;
	end
endmodule : tb
`default_nettype wire
